// *** rxdpq_top.sv ***
// Receive datapath quality alarm, output conditioning, buffer clear and test pattern control
//
// Overview of operation
// - Six-bit assert threshold, bits 7:2, default ten
// - Six-bit deassert threshold, bits 5:0, default fifteen
// - Bit 6 inverts recovered output data
// - Bit 5 substitutes clock during signal absence
// - Bit 4 mutes output while recovery unlocked
// - Bit 3 mutes output while signal absent
// - Bit 2 mutes output unconditionally
// - Bit 1 auto-clears buffer on errors
// - Bit 0 clears buffer; re-centres write pointer
// - Bit 7 inverts checker input data
// - Checker select: off, PRBS7, PRBS31, user
// - Bit 3 inverts every generated bit
// - Generator select codes; register resets zero
// - PRBS31 output inverted from raw register
// - Six-bit eye opening measure feeds alarm
// - User pattern sent least significant bit first
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module rxdpq_top #(
  parameter int FIFO_DEPTH = rxdpq_pkg::FIFO_DEPTH,
  parameter int FIFO_AW = 3
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [5:0] EYE_OPENING_MEASURE,
  input wire logic INPUT_SIGNAL_ABSENT,
  input wire logic RECOVERY_UNLOCKED,
  input wire logic RX_DATA,
  input wire logic RX_DATA_VALID,
  input wire logic RD_TAKE,
  input wire logic TP_CHK_DATA,
  input wire logic [63:0] USER_PATTERN,
  output logic RD_P,
  output logic RD_N,
  output logic QUALITY_ALARM,
  output logic TP_GEN_DATA,
  output logic TP_CHK_ERROR,
  output logic FIFO_ERROR,
  output logic FIFO_ERR_CLEAR
);
  // Synchronisers for pin inputs
  logic [5:0] eye_s1_q;
  logic [5:0] eye_s2_q;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic signal_absent;
  logic unlocked;
  logic rx_bit;
  logic rx_valid;
  logic rd_take;
  logic chk_bit;

  // Registers
  logic [7:0] qa_assert_cfg_q;
  logic [5:0] qa_deassert_q;
  logic [6:0] path_cfg_q;
  logic [7:0] tp_select_q;
  rxdpq_pkg::rxdpq_alm_t alarm_q;
  rxdpq_pkg::rxdpq_alm_t alarm_d;

  // Bus decode
  logic [7:0] reg_idx;
  logic idx_valid;
  logic bus_wr;
  logic [31:0] rd_word;
  logic rd_hit;

  // Datapath
  logic fifo_clear;
  logic fifo_bit;
  logic fifo_ovf;
  logic fifo_unf;
  logic clk_sub_q;
  logic out_bit;
  logic mute;

  // Pattern logic
  rxdpq_pkg::rxdpq_pat_t gen_mode;
  rxdpq_pkg::rxdpq_pat_t chk_mode;
  logic [rxdpq_pkg::LFSR_W-1:0] gen_lfsr_q;
  logic [5:0] gen_idx_q;
  logic gen_raw;
  logic [rxdpq_pkg::LFSR_W-1:0] chk_hist_q;
  logic [5:0] chk_idx_q;
  logic chk_in;
  logic chk_expect;

  // Maps a select field to a mode; unknown codes disable
  function automatic rxdpq_pkg::rxdpq_pat_t pat_decode(input logic [2:0] code);
    pat_decode = rxdpq_pkg::RXDPQ_PAT_OFF;
    case (code)
      3'h1: pat_decode = rxdpq_pkg::RXDPQ_PAT_PRBS7;
      3'h2: pat_decode = rxdpq_pkg::RXDPQ_PAT_PRBS31;
      3'h3: pat_decode = rxdpq_pkg::RXDPQ_PAT_USER;
      default: pat_decode = rxdpq_pkg::RXDPQ_PAT_OFF;
    endcase
  endfunction

  // Two-stage capture of eye measure and pin levels; RD_TAKE and USER_PATTERN used directly
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      eye_s1_q <= '0;
      eye_s2_q <= '0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      eye_s1_q <= EYE_OPENING_MEASURE;
      eye_s2_q <= eye_s1_q;
      pin_s1_q <= {INPUT_SIGNAL_ABSENT, RECOVERY_UNLOCKED, RX_DATA, RX_DATA_VALID, TP_CHK_DATA};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign signal_absent = pin_s2_q[4];
  assign unlocked = pin_s2_q[3];
  assign rx_bit = pin_s2_q[2];
  assign rx_valid = pin_s2_q[1];
  assign chk_bit = pin_s2_q[0];
  assign rd_take = RD_TAKE;

  // Address decode: word index from the byte address
  assign reg_idx = PADDR[rxdpq_pkg::ADDR_SHIFT+7:rxdpq_pkg::ADDR_SHIFT];
  assign idx_valid = (PADDR[1:0] == 2'h0) && (PADDR[31:10] == '0) &&
                     ((reg_idx == rxdpq_pkg::IDX_EYE_MEASURE) || (reg_idx == rxdpq_pkg::IDX_QA_ASSERT_CFG) ||
                      (reg_idx == rxdpq_pkg::IDX_QA_DEASSERT) || (reg_idx == rxdpq_pkg::IDX_PATH_CFG) ||
                      (reg_idx == rxdpq_pkg::IDX_TP_SELECT) || (reg_idx == rxdpq_pkg::IDX_STATUS));
  assign bus_wr = PSEL && PENABLE && PREADY && PWRITE && idx_valid;

  // Read mux; unused upper bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (reg_idx)
      rxdpq_pkg::IDX_EYE_MEASURE: rd_word = {26'h0, eye_s2_q};
      rxdpq_pkg::IDX_QA_ASSERT_CFG: rd_word = {24'h0, qa_assert_cfg_q};
      rxdpq_pkg::IDX_QA_DEASSERT: rd_word = {26'h0, qa_deassert_q};
      rxdpq_pkg::IDX_PATH_CFG: rd_word = {25'h0, path_cfg_q};
      rxdpq_pkg::IDX_TP_SELECT: rd_word = {24'h0, tp_select_q};
      rxdpq_pkg::IDX_STATUS: rd_word = {28'h0, QUALITY_ALARM, unlocked, signal_absent, mute};
      default: rd_hit = 1'b0;
    endcase
  end

  // Bus answer: ready for one cycle of the access phase
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !(idx_valid && rd_hit);
      if (PSEL && !PENABLE && !PWRITE && idx_valid) begin
        PRDATA <= rd_word;
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // Quality threshold registers
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      qa_assert_cfg_q <= rxdpq_pkg::RST_QA_ASSERT_CFG;
      qa_deassert_q <= rxdpq_pkg::RST_QA_DEASSERT;
    end else if (bus_wr) begin
      if (reg_idx == rxdpq_pkg::IDX_QA_ASSERT_CFG) begin
        qa_assert_cfg_q <= PWDATA[7:0];
      end
      if (reg_idx == rxdpq_pkg::IDX_QA_DEASSERT) begin
        qa_deassert_q <= PWDATA[5:0];
      end
    end
  end

  // Path and pattern configuration registers
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      path_cfg_q <= rxdpq_pkg::RST_PATH_CFG;
      tp_select_q <= rxdpq_pkg::RST_TP_SELECT;
    end else if (bus_wr) begin
      if (reg_idx == rxdpq_pkg::IDX_PATH_CFG) begin
        path_cfg_q <= PWDATA[6:0];
      end
      if (reg_idx == rxdpq_pkg::IDX_TP_SELECT) begin
        tp_select_q <= PWDATA[7:0];
      end
    end
  end

  // Alarm with hysteresis between the two thresholds
  always_comb begin
    alarm_d = alarm_q;
    case (alarm_q)
      rxdpq_pkg::RXDPQ_ALM_CLEAR: begin
        if (eye_s2_q <= qa_assert_cfg_q[rxdpq_pkg::QA_THR_MSB:rxdpq_pkg::QA_THR_LSB]) begin
          alarm_d = rxdpq_pkg::RXDPQ_ALM_SET;
        end
      end
      rxdpq_pkg::RXDPQ_ALM_SET: begin
        if (eye_s2_q >= qa_deassert_q) begin
          alarm_d = rxdpq_pkg::RXDPQ_ALM_CLEAR;
        end
      end
      default: alarm_d = rxdpq_pkg::RXDPQ_ALM_CLEAR;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      alarm_q <= rxdpq_pkg::RXDPQ_ALM_CLEAR;
      QUALITY_ALARM <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      QUALITY_ALARM <= (alarm_d == rxdpq_pkg::RXDPQ_ALM_SET);
    end
  end

  // Buffer clear: held while manual bit set, or on error with auto clear
  assign fifo_clear = path_cfg_q[rxdpq_pkg::PC_MANUAL_CLEAR] ||
                      (path_cfg_q[rxdpq_pkg::PC_AUTO_CLEAR] && (fifo_ovf || fifo_unf));

  rxdpq_fifo #(
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .clear(fifo_clear),
    .wr_en(rx_valid),
    .wr_data(rx_bit),
    .rd_en(rd_take),
    .rd_data(fifo_bit),
    .overflow(fifo_ovf),
    .underflow(fifo_unf)
  );

  // Error report, and clear request for the receive interrupt register
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FIFO_ERROR <= 1'b0;
      FIFO_ERR_CLEAR <= 1'b0;
    end else begin
      FIFO_ERROR <= fifo_ovf || fifo_unf;
      FIFO_ERR_CLEAR <= path_cfg_q[rxdpq_pkg::PC_AUTO_CLEAR] && (fifo_ovf || fifo_unf);
    end
  end

  // Substitute clock toggles every cycle, the fastest this clock allows
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clk_sub_q <= 1'b0;
    end else begin
      clk_sub_q <= !clk_sub_q;
    end
  end

  // Output conditioning; any mute wins over clock substitution
  assign mute = path_cfg_q[rxdpq_pkg::PC_MUTE] ||
                (path_cfg_q[rxdpq_pkg::PC_MUTE_UNLOCK] && unlocked) ||
                (path_cfg_q[rxdpq_pkg::PC_MUTE_ABSENT] && signal_absent);
  assign out_bit = (path_cfg_q[rxdpq_pkg::PC_CLK_SUB] && signal_absent) ? clk_sub_q :
                   (fifo_bit ^ path_cfg_q[rxdpq_pkg::PC_INVERT]);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_P <= 1'b0;
      RD_N <= 1'b0;
    end else begin
      RD_P <= mute ? 1'b0 : out_bit;
      RD_N <= mute ? 1'b0 : !out_bit;
    end
  end

  // Generator: one bit per clock from the selected source
  assign gen_mode = pat_decode(tp_select_q[rxdpq_pkg::TS_GEN_MSB:rxdpq_pkg::TS_GEN_LSB]);
  always_comb begin
    case (gen_mode)
      rxdpq_pkg::RXDPQ_PAT_PRBS7: gen_raw = gen_lfsr_q[6];
      rxdpq_pkg::RXDPQ_PAT_PRBS31: gen_raw = !gen_lfsr_q[30];
      rxdpq_pkg::RXDPQ_PAT_USER: gen_raw = USER_PATTERN[gen_idx_q];
      default: gen_raw = 1'b0;
    endcase
  end

  // Shift register seeds only while disabled, so PRBS31 to PRBS7 needs a stop
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gen_lfsr_q <= '1;
      gen_idx_q <= '0;
    end else if (gen_mode == rxdpq_pkg::RXDPQ_PAT_OFF) begin
      gen_lfsr_q <= '1;
      gen_idx_q <= '0;
    end else begin
      gen_idx_q <= gen_idx_q + 6'h01;
      if (gen_mode == rxdpq_pkg::RXDPQ_PAT_PRBS7) begin
        gen_lfsr_q <= {gen_lfsr_q[29:0], gen_lfsr_q[6] ^ gen_lfsr_q[5]};
      end else begin
        gen_lfsr_q <= {gen_lfsr_q[29:0], gen_lfsr_q[30] ^ gen_lfsr_q[27]};
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TP_GEN_DATA <= 1'b0;
    end else begin
      TP_GEN_DATA <= (gen_mode == rxdpq_pkg::RXDPQ_PAT_OFF) ? 1'b0 :
                     (gen_raw ^ tp_select_q[rxdpq_pkg::TS_GEN_INV]);
    end
  end

  // Checker: PRBS modes self-synchronise on the received history; user mode indexes from enable
  assign chk_mode = pat_decode(tp_select_q[rxdpq_pkg::TS_CHK_MSB:rxdpq_pkg::TS_CHK_LSB]);
  assign chk_in = chk_bit ^ tp_select_q[rxdpq_pkg::TS_CHK_INV] ^
                  (chk_mode == rxdpq_pkg::RXDPQ_PAT_PRBS31);
  always_comb begin
    case (chk_mode)
      rxdpq_pkg::RXDPQ_PAT_PRBS7: chk_expect = chk_hist_q[6] ^ chk_hist_q[5];
      rxdpq_pkg::RXDPQ_PAT_PRBS31: chk_expect = chk_hist_q[30] ^ chk_hist_q[27];
      rxdpq_pkg::RXDPQ_PAT_USER: chk_expect = USER_PATTERN[chk_idx_q];
      default: chk_expect = chk_in;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      chk_hist_q <= '0;
      chk_idx_q <= '0;
      TP_CHK_ERROR <= 1'b0;
    end else if (chk_mode == rxdpq_pkg::RXDPQ_PAT_OFF) begin
      chk_hist_q <= '0;
      chk_idx_q <= '0;
      TP_CHK_ERROR <= 1'b0;
    end else begin
      chk_hist_q <= {chk_hist_q[29:0], chk_in};
      chk_idx_q <= chk_idx_q + 6'h01;
      TP_CHK_ERROR <= (chk_in != chk_expect);
    end
  end
endmodule

// *** rxdpq_pkg.sv ***
// Register map, field layout, reset values and codes for the receive datapath control block
package rxdpq_pkg;
  // Printed register indices; the byte address is four times the index
  localparam logic [7:0] IDX_EYE_MEASURE = 8'h19;
  localparam logic [7:0] IDX_QA_ASSERT_CFG = 8'h1A;
  localparam logic [7:0] IDX_QA_DEASSERT = 8'h1B;
  localparam logic [7:0] IDX_PATH_CFG = 8'h1C;
  localparam logic [7:0] IDX_TP_SELECT = 8'h1D;
  localparam logic [7:0] IDX_STATUS = 8'h3F;
  localparam int ADDR_SHIFT = 2;

  // Reset values
  localparam logic [7:0] RST_QA_ASSERT_CFG = 8'h29;
  localparam logic [5:0] RST_QA_DEASSERT = 6'h0F;
  localparam logic [6:0] RST_PATH_CFG = 7'h00;
  localparam logic [7:0] RST_TP_SELECT = 8'h00;

  // Assert configuration fields
  localparam int QA_THR_MSB = 7;
  localparam int QA_THR_LSB = 2;

  // Path configuration bit positions
  localparam int PC_INVERT = 6;
  localparam int PC_CLK_SUB = 5;
  localparam int PC_MUTE_UNLOCK = 4;
  localparam int PC_MUTE_ABSENT = 3;
  localparam int PC_MUTE = 2;
  localparam int PC_AUTO_CLEAR = 1;
  localparam int PC_MANUAL_CLEAR = 0;

  // Pattern select fields
  localparam int TS_CHK_INV = 7;
  localparam int TS_CHK_MSB = 6;
  localparam int TS_CHK_LSB = 4;
  localparam int TS_GEN_INV = 3;
  localparam int TS_GEN_MSB = 2;
  localparam int TS_GEN_LSB = 0;

  // Pattern modes
  typedef enum logic [2:0] {
    RXDPQ_PAT_OFF = 3'h0,
    RXDPQ_PAT_PRBS7 = 3'h1,
    RXDPQ_PAT_PRBS31 = 3'h2,
    RXDPQ_PAT_USER = 3'h3
  } rxdpq_pat_t;

  // Quality alarm states
  typedef enum logic [1:0] {
    RXDPQ_ALM_CLEAR = 2'h0,
    RXDPQ_ALM_SET = 2'h1
  } rxdpq_alm_t;

  // Receive buffer geometry and pattern widths
  localparam int FIFO_DEPTH = 8;
  localparam int LFSR_W = 31;
  localparam int USER_W = 64;
endpackage

// *** rxdpq_fifo.sv ***
// Receive elastic buffer with centring clear and error detection
`timescale 1ns/100ps
module rxdpq_fifo #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic wr_data,
  input wire logic rd_en,
  output logic rd_data,
  output logic overflow,
  output logic underflow
);
  localparam logic [AW:0] CENTRE = (AW+1)'(DEPTH / 2);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [DEPTH-1:0] mem_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic do_wr;
  logic do_rd;

  // Error detection and effective moves
  assign overflow = wr_en && !rd_en && (count_q == FULL);
  assign underflow = rd_en && !wr_en && (count_q == '0);
  assign do_wr = wr_en && !overflow;
  assign do_rd = rd_en && !underflow;

  // Storage; a clear zeroes every stored bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q <= '0;
    end else if (clear) begin
      mem_q <= '0;
    end else if (do_wr) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  // Pointers; a clear puts the write pointer half the depth ahead
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= CENTRE[AW-1:0];
      count_q <= CENTRE;
    end else if (clear) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= CENTRE[AW-1:0];
      count_q <= CENTRE;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 1'b0;
    end else if (do_rd) begin
      rd_data <= mem_q[rd_ptr_q];
    end
  end
endmodule

// *** rxdpq_checker.sv ***
// Port-level assertions for the receive datapath control block
`timescale 1ns/100ps
module rxdpq_checker #(
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_AW = 3
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [5:0] EYE_OPENING_MEASURE,
  input wire logic INPUT_SIGNAL_ABSENT,
  input wire logic RECOVERY_UNLOCKED,
  input wire logic RD_P,
  input wire logic RD_N,
  input wire logic QUALITY_ALARM,
  input wire logic TP_GEN_DATA,
  input wire logic FIFO_ERROR,
  input wire logic FIFO_ERR_CLEAR
);
  logic [7:0] thr_q;
  logic [7:0] dth_q;
  logic [7:0] cfg_q;
  logic [2:0] gen_q;
  logic mapped;
  logic muted;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // Address decode and muted pair
  assign mapped = PADDR inside {32'h64, 32'h68, 32'h6C, 32'h70, 32'h74, 32'hFC};
  assign muted = !RD_P && !RD_N;
  // Shadow copies of settings written over the bus
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      thr_q <= 8'h29;
      dth_q <= 8'h0F;
      cfg_q <= 8'h00;
      gen_q <= 3'h0;
    end else if (PSEL && PENABLE && PREADY && PWRITE) begin
      case (PADDR)
        32'h68: thr_q <= PWDATA[7:0];
        32'h6C: dth_q <= PWDATA[7:0];
        32'h70: cfg_q <= PWDATA[7:0];
        32'h74: gen_q <= PWDATA[2:0];
        default: ;
      endcase
    end
  end
  chk_ready_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  chk_err_decode: assert property (PSEL && !PENABLE |=> PSLVERR == !$past(mapped)) else $error("bad error flag");
  chk_mute_forced: assert property (cfg_q[2] |=> muted) else $error("pair not muted");
  chk_absent_mute: assert property ((cfg_q[3] && INPUT_SIGNAL_ABSENT) [*4] |=> muted) else $error("no mute");
  chk_unlock_mute: assert property ((cfg_q[4] && RECOVERY_UNLOCKED) [*4] |=> muted) else $error("no mute");
  chk_clock_swap: assert property ((cfg_q[5:2] == 4'h8 && INPUT_SIGNAL_ABSENT) [*4] |=>
    RD_P != $past(RD_P) && RD_N == !RD_P) else $error("no substitute clock");
  chk_alarm_set: assert property ((EYE_OPENING_MEASURE <= thr_q[7:2]) [*4] |=> QUALITY_ALARM)
    else $error("alarm not raised");
  chk_alarm_clear: assert property ((EYE_OPENING_MEASURE >= dth_q[5:0]) [*4] |=> !QUALITY_ALARM)
    else $error("alarm not removed");
  chk_auto_clear: assert property (FIFO_ERROR && cfg_q[1] && $past(cfg_q[1]) && $past(cfg_q[1], 2)
    |-> ##[0:1] FIFO_ERR_CLEAR) else $error("no error clear");
  chk_manual_noclr: assert property (!cfg_q[1] && !$past(cfg_q[1]) && !$past(cfg_q[1], 2)
    |-> !FIFO_ERR_CLEAR) else $error("stray error clear");
  chk_gen_off: assert property ((gen_q[2] || gen_q[1:0] == 2'h0) [*3] |-> !TP_GEN_DATA)
    else $error("generator active");
endmodule

bind rxdpq_top rxdpq_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) chk_i (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EYE_OPENING_MEASURE(EYE_OPENING_MEASURE), .INPUT_SIGNAL_ABSENT(INPUT_SIGNAL_ABSENT),
  .RECOVERY_UNLOCKED(RECOVERY_UNLOCKED), .RD_P(RD_P), .RD_N(RD_N), .QUALITY_ALARM(QUALITY_ALARM),
  .TP_GEN_DATA(TP_GEN_DATA), .FIFO_ERROR(FIFO_ERROR), .FIFO_ERR_CLEAR(FIFO_ERR_CLEAR));

// *** rxdpq_host_rx.sv ***
// Host-side serial receiver model fed by the recovered-data pair
`timescale 1ns/100ps
module rxdpq_host_rx (
  input wire logic clk,
  input wire logic en,
  input wire logic rd_p,
  input wire logic rd_n,
  output logic take = 1'b0,
  output logic bit_q,
  output logic mute_q
);
  // Pull one bit a cycle while enabled and record what the pair shows
  always_ff @(posedge clk) begin
    take <= en;
    bit_q <= rd_p;
    mute_q <= !rd_p && !rd_n;
  end
endmodule

// *** rxdpq_tb_top.sv ***
// Self-checking bench for the receive datapath control block
`timescale 1ns/100ps
module rxdpq_tb_top;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] x;
    logic e;
  } rxdpq_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] eye = 6'h0;
  logic absent = 1'b0;
  logic unlock = 1'b0;
  logic en = 1'b0;
  logic chk_d = 1'b0;
  logic rxd = 1'b0;
  logic rxv = 1'b0;
  logic [63:0] upat = 64'hB;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [255:0] cap;
  logic pready, pslverr, rd_p, rd_n, alarm, gen, chk_err, f_err, f_clr, take, hbit, hmute, er, ok, p;
  int errs, ferr, fclr, bad_count, total_checks;
  rxdpq_row_t rows [12] = '{
    '{1'b0, 8'h68, 8'h00, 8'h29, 1'b0},
    '{1'b0, 8'h6C, 8'h00, 8'h0F, 1'b0},
    '{1'b0, 8'h70, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h74, 8'h00, 8'h00, 1'b0},
    '{1'b1, 8'h6C, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 8'h6C, 8'h00, 8'h3F, 1'b0},
    '{1'b1, 8'h6C, 8'h0F, 8'h00, 1'b0},
    '{1'b1, 8'h70, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 8'h70, 8'h00, 8'h7F, 1'b0},
    '{1'b1, 8'h70, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h80, 8'h00, 8'h00, 1'b1},
    '{1'b0, 8'h69, 8'h00, 8'h00, 1'b1}};
  logic [5:0] ev [5] = '{6'h14, 6'h0A, 6'h0E, 6'h0F, 6'h0B};
  logic [4:0] ea = 5'h06;
  logic [7:0] gc [7] = '{8'h00, 8'h01, 8'h09, 8'h04, 8'h05, 8'h06, 8'h07};
  int go [7] = '{32'h0, 32'h40, 32'h3F, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0] cc [6] = '{8'h33, 8'h22, 8'h00, 8'h11, 8'h41, 8'h91};

  rxdpq_top #(.FIFO_DEPTH(8), .FIFO_AW(3)) dut (
    .REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EYE_OPENING_MEASURE(eye), .INPUT_SIGNAL_ABSENT(absent), .RECOVERY_UNLOCKED(unlock),
    .RX_DATA(rxd), .RX_DATA_VALID(rxv), .RD_TAKE(take), .TP_CHK_DATA(chk_d),
    .USER_PATTERN(upat), .RD_P(rd_p), .RD_N(rd_n), .QUALITY_ALARM(alarm), .TP_GEN_DATA(gen),
    .TP_CHK_ERROR(chk_err), .FIFO_ERROR(f_err), .FIFO_ERR_CLEAR(f_clr));
  rxdpq_host_rx host (.clk(clk), .en(en), .rd_p(rd_p), .rd_n(rd_n), .take(take), .bit_q(hbit), .mute_q(hmute));

  // 100 MHz clock
  always #5 clk = ~clk;
  // Checker input follows the generator
  always @(posedge clk) chk_d <= gen;

  // One bus transfer, started right after a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    // A transfer that never completes counts as a mismatch
    if (pready !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: no ready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask

  // Run n cycles, capturing generator bits and counting event pulses
  task automatic run(input int n);
    cap = '0;
    errs = 0;
    ferr = 0;
    fclr = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      cap[i] = gen;
      errs += (chk_err === 1'b1);
      ferr += (f_err === 1'b1);
      fclr += (f_clr === 1'b1);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].w, {24'h0, rows[i].a}, {24'h0, rows[i].d});
      chk(rd, {24'h0, rows[i].x});
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    apb(1'b1, 32'h70, 32'h41);
    run(5);
    chk({31'h0, hbit}, 32'h1);
    apb(1'b1, 32'h70, 32'h01);
    run(5);
    chk({30'h0, hbit, hmute}, 32'h0);
    for (int b = 2; b < 5; b++) begin
      absent <= (b == 3);
      unlock <= (b == 4);
      apb(1'b1, 32'h70, 32'(1 << b) | 32'h1);
      run(5);
      chk({31'h0, hmute}, 32'h1);
      absent <= 1'b0;
      unlock <= 1'b0;
      run(5);
      chk({31'h0, hmute}, 32'(b == 2));
    end
    absent <= 1'b1;
    apb(1'b1, 32'h70, 32'h21);
    run(5);
    p = hbit;
    run(1);
    chk({31'h0, hbit ^ p}, 32'h1);
    absent <= 1'b0;
    en <= 1'b1;
    apb(1'b1, 32'h70, 32'h01);
    run(20);
    chk(ferr, 32'h0);
    apb(1'b1, 32'h70, 32'h00);
    run(20);
    chk(ferr, 32'(20 - rxdpq_pkg::FIFO_DEPTH / 2));
    chk(fclr, 32'h0);
    apb(1'b1, 32'h70, 32'h02);
    run(20);
    chk({31'h0, fclr > 0}, 32'h1);
    en <= 1'b0;
    rxd <= 1'b1;
    rxv <= 1'b1;
    apb(1'b1, 32'h70, 32'h00);
    run(20);
    chk({31'h0, ferr > 0}, 32'h1);
    en <= 1'b1;
    run(20);
    chk({31'h0, hbit}, 32'h1);
    rxv <= 1'b0;
    en <= 1'b0;
    foreach (ev[i]) begin
      eye <= ev[i];
      run(6);
      chk({31'h0, alarm}, {31'h0, ea[i]});
    end
    apb(1'b1, 32'h68, 32'h51);
    run(6);
    chk({31'h0, alarm}, 32'h1);
    apb(1'b0, 32'hFC, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, 32'h64, 32'h0);
    chk(rd, 32'hB);
    apb(1'b1, 32'h74, 32'h03);
    run(140);
    ok = 1'b0;
    for (int i = 10; i < 74; i++) if (cap[i +: 64] === upat) ok = 1'b1;
    chk({31'h0, ok}, 32'h1);
    foreach (gc[i]) begin
      apb(1'b1, 32'h74, {24'h0, gc[i]});
      run(140);
      chk(32'($countones(cap[139:13])), go[i]);
    end
    // Four-bit periodic pattern so the user checker sees no errors
    upat <= 64'h2222_2222_2222_2222;
    foreach (cc[i]) begin
      apb(1'b1, 32'h74, {24'h0, cc[i]});
      run(100);
      run(150);
      chk({31'h0, errs > 0}, {31'h0, cc[i][7]});
    end
    apb(1'b1, 32'h74, 32'hA5);
    rst_b <= 1'b0;
    run(2);
    rst_b <= 1'b1;
    run(1);
    apb(1'b0, 32'h68, 32'h0);
    chk(rd, 32'h29);
    apb(1'b0, 32'h74, 32'h0);
    chk(rd, 32'h0);
    complete_run();
  end

  // Cut a hang short
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule
